// File: gain_amp_pkg.sv
// constants shared by the input gain amplifier control block
package gain_amp_pkg;

   // ****************************************************************
   // register indices, byte address is four times the index
   // ****************************************************************
   localparam logic [5:0] POWER_ENABLES_INDEX   = 6'h02;
   localparam logic [5:0] LEFT_FIRST_VOL_INDEX  = 6'h18;
   localparam logic [5:0] LEFT_SECOND_VOL_INDEX = 6'h19;
   localparam logic [5:0] RIGHT_FIRST_VOL_INDEX = 6'h1A;
   localparam logic [5:0] RIGHT_SECOND_VOL_INDEX = 6'h1B;
   localparam logic [5:0] INPUT_SELECT_INDEX    = 6'h28;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int         POWER_ENABLE_LSB   = 4;
   localparam int         GAIN_UPDATE_BIT    = 8;
   localparam int         MUTE_BIT           = 7;
   localparam int         ZERO_CROSS_BIT     = 6;
   localparam int         GAIN_MSB           = 4;
   localparam logic [4:0] GAIN_RESET         = 5'b01011;
   localparam logic       MUTE_RESET         = 1'b1;
   localparam logic       ZERO_CROSS_RESET   = 1'b0;
   localparam logic [3:0] POWER_RESET        = 4'h0;
   localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;

   // ****************************************************************
   // amplifier numbering: 0 right first, 1 right second, 2 left first, 3 left second
   // ****************************************************************
   localparam int NUM_AMPS = 4;

   // ****************************************************************
   // timeout tick pacing
   // ****************************************************************
   localparam int         DIVIDER_WIDTH       = 3;
   localparam int         TICK_COUNT_WIDTH    = 16;
   localparam int         TIMEOUT_BASE_CYCLES = 256;

   typedef enum logic [0:0] {
      GAIN_IDLE    = 1'b0,
      GAIN_WAITING = 1'b1
   } gain_state_type;

   // volume register index to amplifier number
   function automatic logic [1:0] amp_of_vol_index(input logic [5:0] idx);
      logic [1:0] amp;
      amp = 2'd0;
      if (idx == LEFT_FIRST_VOL_INDEX) amp = 2'd2;
      if (idx == LEFT_SECOND_VOL_INDEX) amp = 2'd3;
      if (idx == RIGHT_FIRST_VOL_INDEX) amp = 2'd0;
      if (idx == RIGHT_SECOND_VOL_INDEX) amp = 2'd1;
      return amp;
   endfunction : amp_of_vol_index

   function automatic logic is_vol_index(input logic [5:0] idx);
      return (idx >= LEFT_FIRST_VOL_INDEX) && (idx <= RIGHT_SECOND_VOL_INDEX);
   endfunction : is_vol_index

endpackage : gain_amp_pkg

// File: timeout_tick_gen.sv
// timeout tick generator paced by the divider
`timescale 1ns/1ps
`default_nettype none
module timeout_tick_gen #(
   parameter int unsigned BASE_CYCLES = gain_amp_pkg::TIMEOUT_BASE_CYCLES
) (
   // clock and reset
   input  wire  logic                                   ref_clk,
   input  wire  logic                                   rst_sync_b,
   // pacing
   input  wire  logic                                   tick_enable,
   input  wire  logic [gain_amp_pkg::DIVIDER_WIDTH-1:0] tick_divider,
   // tick
   output logic                                         tick
);
   localparam int CW = gain_amp_pkg::TICK_COUNT_WIDTH + 8;

   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic [CW-1:0] period;
   wire           at_end;

   // divider doubles the period per step
   assign period  = CW'(BASE_CYCLES) << tick_divider;
   assign at_end  = (count_q >= period - CW'(1));
   assign count_d = (!tick_enable || at_end) ? '0 : count_q + CW'(1);

   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         count_q <= '0;
         tick    <= 1'b0;
      end else begin
         count_q <= count_d;
         tick    <= tick_enable && at_end;
      end
   end
endmodule : timeout_tick_gen
`default_nettype wire

// File: amp_gain_channel.sv
// one amplifier's gain apply and mute arming logic
`timescale 1ns/1ps
`default_nettype none
module amp_gain_channel (
   // clock and reset
   input  wire  logic       ref_clk,
   input  wire  logic       rst_sync_b,
   // register state
   input  wire  logic [4:0] stored_gain,
   input  wire  logic       zero_cross_sel,
   input  wire  logic       mute_bit,
   input  wire  logic       update_strobe,
   // events
   input  wire  logic       zero_cross_seen,
   input  wire  logic       timeout_tick,
   // applied state
   output logic [4:0]       active_gain,
   output logic             mute_active,
   output logic             gain_pending
);
   gain_amp_pkg::gain_state_type state_q;
   gain_amp_pkg::gain_state_type state_d;
   logic                         armed_q;
   wire                          apply_now;

   // zero-cross off applies in the strobe cycle, on waits for crossing or timeout
   assign apply_now = (update_strobe && !zero_cross_sel)
                    || (state_q == gain_amp_pkg::GAIN_WAITING
                        && (!zero_cross_sel || zero_cross_seen || timeout_tick));

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         gain_amp_pkg::GAIN_IDLE: begin
            if (update_strobe && zero_cross_sel) state_d = gain_amp_pkg::GAIN_WAITING;
         end
         gain_amp_pkg::GAIN_WAITING: begin
            // a fresh strobe in the apply cycle keeps the request alive
            if (apply_now && !update_strobe) state_d = gain_amp_pkg::GAIN_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_q     <= gain_amp_pkg::GAIN_IDLE;
         active_gain <= gain_amp_pkg::GAIN_RESET;
         armed_q     <= 1'b0;
         mute_active <= 1'b0;
      end else begin
         state_q <= state_d;
         if (apply_now) active_gain <= stored_gain;
         armed_q     <= armed_q | ~mute_bit;
         mute_active <= mute_bit & armed_q;
      end
   end

   assign gain_pending = (state_q == gain_amp_pkg::GAIN_WAITING);
endmodule : amp_gain_channel
`default_nettype wire

// File: input_gain_amp_control.sv
// register bank and control of the four input gain amplifiers
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module input_gain_amp_control #(
   parameter int unsigned TIMEOUT_BASE_CYCLES = gain_amp_pkg::TIMEOUT_BASE_CYCLES
) (
   // clock and reset
   input  wire  logic                                   ref_clk,
   input  wire  logic                                   rst_b,
   // apb slave
   input  wire  logic                                   psel,
   input  wire  logic                                   penable,
   input  wire  logic                                   pwrite,
   input  wire  logic [7:0]                             paddr,
   input  wire  logic [31:0]                            pwdata,
   output logic [31:0]                                  prdata,
   output logic                                         pready,
   output logic                                         pslverr,
   // timeout pacing from the clocking block
   input  wire  logic                                   timeout_tick_enable,
   input  wire  logic [gain_amp_pkg::DIVIDER_WIDTH-1:0] timeout_tick_divider,
   // zero crossings seen by the analogue detectors, one per amplifier
   input  wire  logic [3:0]                             zero_cross_detect,
   // amplifier power enables
   output logic                                         left_first_amp_enable,
   output logic                                         left_second_amp_enable,
   output logic                                         right_first_amp_enable,
   output logic                                         right_second_amp_enable,
   // input switch controls
   output logic                                         left_first_noninv_select,
   output logic                                         left_first_inv_select,
   output logic                                         left_second_noninv_select,
   output logic                                         left_second_inv_select,
   output logic                                         right_first_noninv_select,
   output logic                                         right_first_inv_select,
   output logic                                         right_second_noninv_select,
   output logic                                         right_second_inv_select,
   // active gain codes, shared by both inputs of each amplifier
   output logic [4:0]                                   left_first_gain_code,
   output logic [4:0]                                   left_second_gain_code,
   output logic [4:0]                                   right_first_gain_code,
   output logic [4:0]                                   right_second_gain_code,
   // effective mutes
   output logic                                         left_first_amp_mute,
   output logic                                         left_second_amp_mute,
   output logic                                         right_first_amp_mute,
   output logic                                         right_second_amp_mute,
   // gain change still waiting for a crossing
   output logic [3:0]                                   gain_pending
);

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_meta_q;
   logic rst_sync_b;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_b <= rst_meta_q;
      end
   end

   // ****************************************************************
   // bus decode
   // ****************************************************************
   wire [5:0] reg_index;
   wire       aligned;
   wire       hit_power;
   wire       hit_select;
   wire       hit_vol;
   wire       mapped;
   wire       setup_phase;
   wire       access_done;
   wire       wr_en;
   wire [1:0] wr_amp;

   assign reg_index   = paddr[7:2];
   assign aligned     = (paddr[1:0] == 2'b00);
   assign hit_power   = aligned && (reg_index == gain_amp_pkg::POWER_ENABLES_INDEX);
   assign hit_select  = aligned && (reg_index == gain_amp_pkg::INPUT_SELECT_INDEX);
   assign hit_vol     = aligned && gain_amp_pkg::is_vol_index(reg_index);
   assign mapped      = hit_power || hit_select || hit_vol;
   assign setup_phase = psel && !penable;
   assign access_done = psel && penable && pready;
   assign wr_en       = access_done && pwrite && mapped;
   assign wr_amp      = gain_amp_pkg::amp_of_vol_index(reg_index);

   // no wait state: read data is captured in the setup cycle
   assign pready  = psel && penable;
   assign pslverr = psel && penable && !mapped;

   // ****************************************************************
   // control registers
   // ****************************************************************
   logic [3:0] power_q;
   logic [7:0] select_q;
   logic [4:0] gain_q  [gain_amp_pkg::NUM_AMPS];
   logic       mute_q  [gain_amp_pkg::NUM_AMPS];
   logic       zc_q    [gain_amp_pkg::NUM_AMPS];

   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         power_q  <= gain_amp_pkg::POWER_RESET;
         select_q <= gain_amp_pkg::INPUT_SELECT_RESET;
      end else if (wr_en) begin
         if (hit_power) power_q <= pwdata[gain_amp_pkg::POWER_ENABLE_LSB +: 4];
         if (hit_select) select_q <= pwdata[7:0];
      end
   end

   // gain, mute and zero-cross fields per amplifier
   for (genvar i = 0; i < gain_amp_pkg::NUM_AMPS; i++) begin : g_vol
      always_ff @(posedge ref_clk or negedge rst_sync_b) begin
         if (!rst_sync_b) begin
            gain_q[i] <= gain_amp_pkg::GAIN_RESET;
            mute_q[i] <= gain_amp_pkg::MUTE_RESET;
            zc_q[i]   <= gain_amp_pkg::ZERO_CROSS_RESET;
         end else if (wr_en && hit_vol && wr_amp == 2'(i)) begin
            gain_q[i] <= pwdata[gain_amp_pkg::GAIN_MSB:0];
            mute_q[i] <= pwdata[gain_amp_pkg::MUTE_BIT];
            zc_q[i]   <= pwdata[gain_amp_pkg::ZERO_CROSS_BIT];
         end
      end
   end

   // ****************************************************************
   // pair update strobes
   // ****************************************************************
   // live for the write cycle only, the strobe bit itself is not stored in any register field
   wire strobe_bit;
   wire first_pair_gain_update;
   wire second_pair_gain_update;
   wire [3:0] amp_update;

   assign strobe_bit = wr_en && hit_vol && pwdata[gain_amp_pkg::GAIN_UPDATE_BIT];
   assign first_pair_gain_update  = strobe_bit && !wr_amp[0];
   assign second_pair_gain_update = strobe_bit && wr_amp[0];
   assign amp_update = {second_pair_gain_update, first_pair_gain_update,
                        second_pair_gain_update, first_pair_gain_update};

   // one cycle late so a gain written together with its strobe is already stored when applied
   logic [3:0] amp_update_q;

   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         amp_update_q <= 4'h0;
      end else begin
         amp_update_q <= amp_update;
      end
   end

   // ****************************************************************
   // timeout tick
   // ****************************************************************
   logic timeout_tick;

   timeout_tick_gen #(
      .BASE_CYCLES (TIMEOUT_BASE_CYCLES)
   ) u_tick (
      .ref_clk      (ref_clk),
      .rst_sync_b   (rst_sync_b),
      .tick_enable  (timeout_tick_enable),
      .tick_divider (timeout_tick_divider),
      .tick         (timeout_tick)
   );

   // ****************************************************************
   // gain application
   // ****************************************************************
   logic [4:0] active_gain [gain_amp_pkg::NUM_AMPS];
   logic [3:0] mute_active;

   for (genvar i = 0; i < gain_amp_pkg::NUM_AMPS; i++) begin : g_amp
      amp_gain_channel u_chan (
         .ref_clk         (ref_clk),
         .rst_sync_b      (rst_sync_b),
         .stored_gain     (gain_q[i]),
         .zero_cross_sel  (zc_q[i]),
         .mute_bit        (mute_q[i]),
         .update_strobe   (amp_update_q[i]),
         .zero_cross_seen (zero_cross_detect[i]),
         .timeout_tick    (timeout_tick),
         .active_gain     (active_gain[i]),
         .mute_active     (mute_active[i]),
         .gain_pending    (gain_pending[i])
      );
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   wire  [31:0] vol_readback;
   wire  [31:0] read_value;

   // strobe bit and bit 5 always read zero
   assign vol_readback = {24'h0000_00, mute_q[wr_amp], zc_q[wr_amp], 1'b0, gain_q[wr_amp]};
   assign read_value   = hit_power  ? {24'h0000_00, power_q, 4'h0} :
                         hit_select ? {24'h0000_00, select_q} :
                         hit_vol    ? vol_readback : 32'h0000_0000;

   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase) begin
         prdata <= (pwrite) ? 32'h0000_0000 : read_value;
      end
   end

   // ****************************************************************
   // analogue-facing outputs
   // ****************************************************************
   assign right_first_amp_enable  = power_q[0];
   assign right_second_amp_enable = power_q[1];
   assign left_first_amp_enable   = power_q[2];
   assign left_second_amp_enable  = power_q[3];

   // non-inverting at odd bits, inverting at even bits
   assign right_first_noninv_select  = select_q[1];
   assign right_second_noninv_select = select_q[3];
   assign left_first_noninv_select   = select_q[5];
   assign left_second_noninv_select  = select_q[7];
   assign right_first_inv_select     = select_q[0];
   assign right_second_inv_select    = select_q[2];
   assign left_first_inv_select      = select_q[4];
   assign left_second_inv_select     = select_q[6];

   // one code drives both input sides of an amplifier
   assign right_first_gain_code  = active_gain[0];
   assign right_second_gain_code = active_gain[1];
   assign left_first_gain_code   = active_gain[2];
   assign left_second_gain_code  = active_gain[3];

   assign right_first_amp_mute  = mute_active[0];
   assign right_second_amp_mute = mute_active[1];
   assign left_first_amp_mute   = mute_active[2];
   assign left_second_amp_mute  = mute_active[3];

endmodule : input_gain_amp_control
`default_nettype wire

// File: input_gain_amp_control_chk.sv
// port assertions for the input gain amplifier control block
`timescale 1ns/1ps
`default_nettype none
module input_gain_amp_control_chk (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_b,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // amplifier side
   input wire logic [3:0]  zero_cross_detect,
   input wire logic        left_first_amp_enable,
   input wire logic        left_second_amp_enable,
   input wire logic        right_first_amp_enable,
   input wire logic        right_second_amp_enable,
   input wire logic        left_first_noninv_select,
   input wire logic        right_first_inv_select,
   input wire logic [4:0]  left_first_gain_code,
   input wire logic [3:0]  gain_pending
);
   // ****************************************************************
   // helpers
   // ****************************************************************
   logic       access;
   logic       wr;
   logic       mapped;
   logic [3:0] ena;
   logic [4:0] gain_hold_q;
   assign access = psel && penable;
   assign wr     = access && pwrite;
   assign mapped = (paddr == 8'h08) || (paddr == 8'h60) || (paddr == 8'h64) || (paddr == 8'h68) ||
                   (paddr == 8'h6C) || (paddr == 8'hA0);
   assign ena    = {left_second_amp_enable, left_first_amp_enable, right_second_amp_enable, right_first_amp_enable};
   // keeps the gain of the last left-first write for the apply check
   always_ff @(posedge ref_clk) begin
      if (wr && paddr == 8'h60) begin
         gain_hold_q <= pwdata[4:0];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // ****************************************************************
   // assertions
   // ****************************************************************
   a_ready_access: assert property (access |-> pready) else $error("no ready in access phase");
   a_ready_idle: assert property (!access |-> !pready) else $error("ready outside access phase");
   a_slverr_map: assert property (access |-> (pslverr == !mapped)) else $error("error response wrong");
   a_slverr_data: assert property (pslverr |-> prdata == 32'h0000_0000) else $error("refused read not zero");
   a_power_write: assert property (wr && paddr == 8'h08 |=> ena == $past(pwdata[7:4]))
      else $error("enables do not follow write");
   a_power_hold: assert property (!(wr && paddr == 8'h08) |=> $stable(ena))
      else $error("enables changed without write");
   a_select_write: assert property (wr && paddr == 8'hA0 |=>
      left_first_noninv_select == $past(pwdata[5]) && right_first_inv_select == $past(pwdata[0]))
      else $error("selects do not follow write");
   a_gain_hold: assert property (wr && paddr == 8'h60 && !pwdata[8] && gain_pending == 4'h0 |=>
      $stable(left_first_gain_code) [*2]) else $error("gain changed without strobe");
   a_gain_apply: assert property (wr && paddr == 8'h60 && pwdata[8] && !pwdata[6] |=>
      ##[0:1] left_first_gain_code == gain_hold_q) else $error("strobed gain not applied");
   a_cross_apply: assert property (gain_pending[2] && zero_cross_detect[2] |-> ##[1:2] !gain_pending[2])
      else $error("crossing did not apply gain");
endmodule : input_gain_amp_control_chk
`default_nettype wire

// File: input_gain_amp_control_tb.sv
// self-checking bench for the input gain amplifier control block
`timescale 1ns/1ps
`default_nettype none
module input_gain_amp_control_tb;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, er;
   logic        timeout_tick_enable = 1'b0;
   logic [2:0]  timeout_tick_divider = 3'h0;
   logic [3:0]  zero_cross_detect = 4'h0, en_v, mute_v, gain_pending;
   logic [7:0]  sel_v;
   logic [4:0]  gain_v [4];
   int          bad_count = 0, checks_done = 0, n;
   always #2 ref_clk = ~ref_clk;
   // amplifier order in the vectors: 3 left second, 2 left first, 1 right second, 0 right first
   input_gain_amp_control #(.TIMEOUT_BASE_CYCLES(4)) dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timeout_tick_enable(timeout_tick_enable), .timeout_tick_divider(timeout_tick_divider),
      .zero_cross_detect(zero_cross_detect), .left_first_amp_enable(en_v[2]), .left_second_amp_enable(en_v[3]),
      .right_first_amp_enable(en_v[0]), .right_second_amp_enable(en_v[1]),
      .left_first_noninv_select(sel_v[5]), .left_first_inv_select(sel_v[4]),
      .left_second_noninv_select(sel_v[7]), .left_second_inv_select(sel_v[6]),
      .right_first_noninv_select(sel_v[1]), .right_first_inv_select(sel_v[0]),
      .right_second_noninv_select(sel_v[3]), .right_second_inv_select(sel_v[2]),
      .left_first_gain_code(gain_v[2]), .left_second_gain_code(gain_v[3]),
      .right_first_gain_code(gain_v[0]), .right_second_gain_code(gain_v[1]),
      .left_first_amp_mute(mute_v[2]), .left_second_amp_mute(mute_v[3]),
      .right_first_amp_mute(mute_v[0]), .right_second_amp_mute(mute_v[1]), .gain_pending(gain_pending));
   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic final_report();
      if (bad_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int c);
      repeat (c) @(posedge ref_clk);
   endtask : step
   // one apb transfer; the request stands until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         bad_count++;
         final_report();
      end
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rdc
   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      step(6);
      rst_b <= 1'b1;
      step(3);
      rdc(8'h08, 32'h0000_0000);
      for (int i = 0; i < 4; i++) rdc(8'h60 + 8'(4 * i), 32'h0000_008B);
      rdc(8'hA0, 32'h0000_0000);
      chk(mute_v, 32'h0000_0000);
      for (int i = 0; i < 4; i++) chk(gain_v[i], 32'h0000_000B);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk({er, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, 8'h61, 32'h0000_0000);
      chk(er, 32'h0000_0001);
      rdc(8'h60, 32'h0000_008B);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'h08, 32'h0000_0010 << i);
         step(1);
         chk(en_v, 32'h0000_0001 << i);
         rdc(8'h08, 32'h0000_0010 << i);
      end
      foreach (sel_v[i]) begin
         apb(1'b1, 8'hA0, 32'h0000_0001 << i);
         step(1);
         chk(sel_v, 32'h0000_0001 << i);
      end
      rdc(8'hA0, 32'h0000_0001);
      apb(1'b1, 8'hA0, 32'h0000_0000);
      step(1);
      chk(sel_v, 32'h0000_0000);
      apb(1'b1, 8'h60, 32'h0000_009F);
      apb(1'b1, 8'h68, 32'h0000_0080);
      step(2);
      chk(gain_v[2], 32'h0000_000B);
      rdc(8'h60, 32'h0000_009F);
      apb(1'b1, 8'h60, 32'h0000_019F);
      step(2);
      chk({gain_v[2], gain_v[0]}, 32'h0000_03E0);
      rdc(8'h60, 32'h0000_009F);
      apb(1'b1, 8'h64, 32'h0000_0090);
      apb(1'b1, 8'h6C, 32'h0000_0195);
      step(2);
      chk({gain_v[3], gain_v[2], gain_v[1]}, 32'h0000_43F5);
      chk(mute_v, 32'h0000_0000);
      apb(1'b1, 8'h60, 32'h0000_001F);
      apb(1'b1, 8'h60, 32'h0000_009F);
      step(2);
      chk(mute_v, 32'h0000_0004);
      apb(1'b1, 8'h60, 32'h0000_01C5);
      step(2);
      chk({gain_pending[2], gain_v[2]}, 32'h0000_003F);
      zero_cross_detect <= 4'h4;
      step(1);
      zero_cross_detect <= 4'h0;
      step(2);
      chk({gain_pending[2], gain_v[2]}, 32'h0000_0005);
      timeout_tick_divider <= 3'h1;
      apb(1'b1, 8'h60, 32'h0000_01C6);
      step(40);
      chk({gain_pending[2], gain_v[2]}, 32'h0000_0025);
      timeout_tick_enable <= 1'b1;
      n = 0;
      while (gain_pending[2] !== 1'b0 && n < 40) begin
         step(1);
         n++;
      end
      step(2);
      chk({gain_pending[2], gain_v[2]}, 32'h0000_0006);
      final_report();
   end
endmodule : input_gain_amp_control_tb
bind input_gain_amp_control input_gain_amp_control_chk u_chk (
   .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .zero_cross_detect(zero_cross_detect),
   .left_first_amp_enable(left_first_amp_enable), .left_second_amp_enable(left_second_amp_enable),
   .right_first_amp_enable(right_first_amp_enable), .right_second_amp_enable(right_second_amp_enable),
   .left_first_noninv_select(left_first_noninv_select), .right_first_inv_select(right_first_inv_select),
   .left_first_gain_code(left_first_gain_code), .gain_pending(gain_pending));
`default_nettype wire
